//--- hw/bbdc_pkg.sv
// Notes on behaviour
// - Run lamp on for user code, off while fetching from top 4K monitor page.
// - Restart resets the system, waits for init, then hands control to monitor.
// - Abort leaves the running routine and returns control to the monitor.
// - Selector picks internal 1 MHz clock or external clock as timing source.
// - Monitor firmware runs only while the monitor-enable selector is on.
// - Scope mode emits a trigger pulse whenever the bus address matches.
// - Stop-on-address mode halts execution at the next instruction on a match.
// - A maskable request is recognised only after the current instruction ends.
// - Maskable interrupt sequence starts only when the condition code mask is clear.
// - Non-maskable request starts its sequence after the instruction, ignoring mask.
// - Abort and stop-on-address both work by raising the non-maskable request.
// - Valid-address qualifier marks a valid address and is never floated.
// - The master timing clock is the base for both phase clocks.
// - Address-float control high releases every address line.
// - Address-float control high forces qualifier and bus-released flag low.
// - Address-float control leaves the data bus drivers untouched.
// - Slow memory holding its line low freezes phase clocks with phase two high.
// - Bus-released flag rises when the processor halts or waits.
package bbdc_pkg;
	localparam int unsigned CLK_HZ     = 100_000_000;
	localparam int unsigned INT_CLK_HZ = 1_000_000;
	localparam int unsigned HALF_CYC   = CLK_HZ / (2 * INT_CLK_HZ);
	localparam int          DIV_W      = 6;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYC - 1);
	localparam int unsigned RST_HOLD   = 8;
	localparam int          RST_W      = 3;
	localparam logic [RST_W-1:0] RST_LAST = RST_W'(RST_HOLD - 1);
	localparam int          ADDR_W     = 16;
	localparam int          DATA_W     = 8;
	localparam int          PAGE_W     = 4;
	localparam logic [PAGE_W-1:0] MON_PAGE = 4'h_F;
	localparam int          PADDR_W    = 12;
	localparam logic [PADDR_W-1:0] OFF_CTRL  = 12'h_000;
	localparam logic [PADDR_W-1:0] OFF_CMP   = 12'h_004;
	localparam logic [PADDR_W-1:0] OFF_STAT  = 12'h_008;
	localparam logic [PADDR_W-1:0] OFF_ISTAT = 12'h_00C;
	localparam logic [PADDR_W-1:0] OFF_IMASK = 12'h_010;
	localparam int CB_EXTCLK  = 0;
	localparam int CB_MONEN   = 1;
	localparam int CB_SCOPE   = 2;
	localparam int CB_RESTART = 3;
	localparam int CB_ABORT   = 4;
	localparam int CTRL_W     = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 3'h_2;
	localparam logic [ADDR_W-1:0] CMP_RST  = 16'h_0000;
	localparam int EV_SCOPE = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_ABORT = 2;
	localparam int EV_READY = 3;
	localparam int EV_IRQ   = 4;
	localparam int EV_NMI   = 5;
	localparam int EV_W     = 6;
	localparam logic [EV_W-1:0] EV_RST = 6'h_00;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_RESET, SEQ_INIT, SEQ_ENTER}
		bbdc_seq_e;
endpackage

//--- hw/bbdc_top.sv
module bbdc_top
	import bbdc_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                pclk_en,
	input  wire logic [PADDR_W-1:0]  paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	output logic                     irq,
	input  wire logic [ADDR_W-1:0]   cpu_addr,
	input  wire logic                cpu_addr_valid,
	input  wire logic [DATA_W-1:0]   cpu_data,
	input  wire logic                cpu_data_drive,
	input  wire logic                cpu_instr_end,
	input  wire logic                cpu_cc_mask,
	input  wire logic                cpu_halted,
	input  wire logic                cpu_waiting,
	input  wire logic                cpu_init_done,
	output logic                     cpu_reset,
	output logic                     cpu_irq_start,
	output logic                     cpu_nmi_start,
	output logic                     cpu_wake,
	output logic                     monitor_go,
	output logic                     monitor_sel,
	input  wire logic                irq_n,
	input  wire logic                nmi_n,
	input  wire logic                address_float_control,
	input  wire logic                slow_memory_hold_n,
	input  wire logic                ext_clk,
	output logic                     master_timing_clock,
	output logic                     phi1,
	output logic                     phi2,
	output logic [ADDR_W-1:0]        addr_o,
	output logic [ADDR_W-1:0]        addr_oe_n,
	output logic [DATA_W-1:0]        data_o,
	output logic                     data_oe_n,
	output logic                     valid_address_qualifier,
	output logic                     bus_released,
	input  wire logic                restart_n,
	input  wire logic                abort_n,
	output logic                     run_led,
	output logic                     scope_trigger
);
	// Bus decode; the slave always answers in the access cycle.
	logic                 wr_en;
	logic                 setup;
	logic                 hit_ctrl;
	logic                 hit_cmp;
	logic                 hit_stat;
	logic                 hit_istat;
	logic                 hit_imask;
	logic                 hit_any;
	assign wr_en     = psel & penable & pwrite;
	assign setup     = psel & ~penable;
	assign hit_ctrl  = (paddr == OFF_CTRL);
	assign hit_cmp   = (paddr == OFF_CMP);
	assign hit_stat  = (paddr == OFF_STAT);
	assign hit_istat = (paddr == OFF_ISTAT);
	assign hit_imask = (paddr == OFF_IMASK);
	assign hit_any   = hit_ctrl | hit_cmp | hit_stat | hit_istat | hit_imask;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~hit_any;

	logic [CTRL_W-1:0]    ctrl_q;
	logic [ADDR_W-1:0]    cmp_q;
	logic [EV_W-1:0]      istat_q;
	logic [EV_W-1:0]      istat_d;
	logic [EV_W-1:0]      imask_q;
	logic [EV_W-1:0]      ev;
	logic [31:0]          prdata_q;
	logic [31:0]          rd_mux;
	logic                 ext_sel;
	logic                 mon_en;
	logic                 scope_mode;
	assign ext_sel    = ctrl_q[CB_EXTCLK];
	assign mon_en     = ctrl_q[CB_MONEN];
	assign scope_mode = ctrl_q[CB_SCOPE];

	// Control, compare and mask registers.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q  <= CTRL_RST;
			cmp_q   <= CMP_RST;
			imask_q <= EV_RST;
		end
		else if (pclk_en && wr_en)
		begin
			if (hit_ctrl)
				ctrl_q <= pwdata[CTRL_W-1:0];
			if (hit_cmp)
				cmp_q <= pwdata[ADDR_W-1:0];
			if (hit_imask)
				imask_q <= pwdata[EV_W-1:0];
		end
	end

	// Sticky events; a new event in the clearing cycle survives.
	assign istat_d = ev | (istat_q & ~((wr_en && hit_istat) ?
		pwdata[EV_W-1:0] : EV_RST));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			istat_q <= EV_RST;
		else if (pclk_en)
			istat_q <= istat_d;
	end
	assign irq = |(istat_q & imask_q);

	// Front panel buttons and software pulses, taken on the falling edge.
	logic                 restart_n_q;
	logic                 abort_n_q;
	logic                 nmi_n_q;
	logic                 restart_evt;
	logic                 abort_evt;
	logic                 nmi_edge;
	assign restart_evt = (restart_n_q & ~restart_n) |
		(wr_en & hit_ctrl & pwdata[CB_RESTART]);
	assign abort_evt   = (abort_n_q & ~abort_n) |
		(wr_en & hit_ctrl & pwdata[CB_ABORT]);
	// Non-maskable line is edge sensitive so a held line fires once.
	assign nmi_edge    = nmi_n_q & ~nmi_n;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			restart_n_q <= 1'b1;
			abort_n_q   <= 1'b1;
			nmi_n_q     <= 1'b1;
		end
		else if (pclk_en)
		begin
			restart_n_q <= restart_n;
			abort_n_q   <= abort_n;
			nmi_n_q     <= nmi_n;
		end
	end

	// Restart sequencer: hold reset, wait for init, enter monitor.
	bbdc_seq_e            seq_q;
	bbdc_seq_e            seq_d;
	logic [RST_W-1:0]     rcnt_q;
	logic                 mgo_q;
	always_comb
	begin
		seq_d = seq_q;
		unique case (seq_q)
			SEQ_IDLE:  seq_d = SEQ_IDLE;
			SEQ_RESET: if (rcnt_q == RST_LAST) seq_d = SEQ_INIT;
			SEQ_INIT:  if (cpu_init_done) seq_d = SEQ_ENTER;
			SEQ_ENTER: seq_d = SEQ_IDLE;
		endcase
		if (restart_evt)
			seq_d = SEQ_RESET;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			seq_q  <= SEQ_RESET;
			rcnt_q <= '0;
			mgo_q  <= 1'b0;
		end
		else if (pclk_en)
		begin
			seq_q  <= seq_d;
			rcnt_q <= (seq_d == SEQ_RESET && seq_q == SEQ_RESET) ?
				rcnt_q + RST_W'(1) : '0;
			// Without the monitor enabled the hand-over is suppressed.
			mgo_q  <= (seq_q == SEQ_ENTER) & mon_en;
		end
	end
	assign cpu_reset  = (seq_q == SEQ_RESET);
	assign monitor_go = mgo_q;

	// Address compare for scope trigger and stop-on-address.
	logic                 in_mon;
	logic                 match;
	logic                 scope_q;
	logic                 run_q;
	assign in_mon      = (cpu_addr[ADDR_W-1 -: PAGE_W] == MON_PAGE);
	assign match       = cpu_addr_valid & (cpu_addr == cmp_q);
	assign monitor_sel = cpu_addr_valid & in_mon & mon_en;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scope_q <= 1'b0;
			run_q   <= 1'b0;
		end
		else if (pclk_en)
		begin
			scope_q <= match & scope_mode;
			if (cpu_addr_valid)
				run_q <= ~in_mon;
		end
	end
	assign scope_trigger = scope_q;
	assign run_led       = run_q;

	// Interrupt sequencing at instruction boundaries. Debug functions
	// share the non-maskable path, so abort and stop-on-address wait
	// for the current instruction like any external request.
	logic                 dbg_q;
	logic                 npend_q;
	logic                 stop_hit;
	logic                 take_nmi;
	logic                 take_irq;
	logic                 irq_q;
	logic                 nmi_q;
	logic                 wake_q;
	assign stop_hit = match & ~scope_mode;
	assign take_nmi = cpu_instr_end & (seq_q == SEQ_IDLE) &
		(npend_q | dbg_q);
	assign take_irq = cpu_instr_end & (seq_q == SEQ_IDLE) & ~take_nmi &
		~irq_n & ~cpu_cc_mask;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dbg_q   <= 1'b0;
			npend_q <= 1'b0;
			irq_q   <= 1'b0;
			nmi_q   <= 1'b0;
			wake_q  <= 1'b0;
		end
		else if (pclk_en)
		begin
			dbg_q   <= abort_evt | stop_hit |
				(dbg_q & ~take_nmi);
			npend_q <= nmi_edge | (npend_q & ~take_nmi);
			irq_q   <= take_irq;
			nmi_q   <= take_nmi;
			wake_q  <= cpu_waiting & (~irq_n | restart_evt | abort_evt);
		end
	end
	assign cpu_irq_start = irq_q;
	assign cpu_nmi_start = nmi_q;
	assign cpu_wake      = wake_q;
	assign ev = {take_nmi, take_irq, (seq_q == SEQ_ENTER), abort_evt,
		stop_hit, match & scope_mode};

	// Timing source: internal 1 MHz divider or the external clock.
	logic [DIV_W-1:0]     div_q;
	logic                 iclk_q;
	logic                 mclk_q;
	logic                 mclk_prev_q;
	logic                 mclk_rise;
	logic                 phi2_q;
	assign mclk_rise = mclk_q & ~mclk_prev_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_q       <= '0;
			iclk_q      <= 1'b0;
			mclk_q      <= 1'b0;
			mclk_prev_q <= 1'b0;
			phi2_q      <= 1'b0;
		end
		else if (pclk_en)
		begin
			div_q       <= (div_q == DIV_LAST) ? '0 : div_q + DIV_W'(1);
			if (div_q == DIV_LAST)
				iclk_q <= ~iclk_q;
			mclk_q      <= ext_sel ? ext_clk : iclk_q;
			mclk_prev_q <= mclk_q;
			// A slow memory freezes the phases with phase two high.
			if (mclk_rise && !(phi2_q && !slow_memory_hold_n))
				phi2_q <= ~phi2_q;
		end
	end
	assign master_timing_clock = mclk_q;
	assign phi2 = phi2_q;
	assign phi1 = ~phi2_q;

	// Backplane drivers; float acts after the flops so it is immediate.
	logic [ADDR_W-1:0]    addr_q;
	logic [DATA_W-1:0]    data_q;
	logic                 vma_q;
	logic                 ba_q;
	logic                 doe_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_q <= '0;
			data_q <= '0;
			vma_q  <= 1'b0;
			ba_q   <= 1'b0;
			doe_q  <= 1'b0;
		end
		else if (pclk_en)
		begin
			addr_q <= cpu_addr;
			data_q <= cpu_data;
			vma_q  <= cpu_addr_valid;
			ba_q   <= cpu_halted | cpu_waiting;
			doe_q  <= cpu_data_drive;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < ADDR_W; gi++)
		begin : g_addr
			assign addr_oe_n[gi] = address_float_control | ba_q;
		end
	endgenerate
	assign addr_o    = addr_q;
	assign data_o    = data_q;
	assign data_oe_n = ~doe_q;
	// Qualifier is a plain driven level, never floated.
	assign valid_address_qualifier = vma_q & ~address_float_control;
	assign bus_released = ba_q & ~address_float_control;

	// Status word and registered read data, captured in the setup cycle.
	always_comb
	begin
		rd_mux = '0;
		if (hit_ctrl)
			rd_mux[CTRL_W-1:0] = ctrl_q;
		if (hit_cmp)
			rd_mux[ADDR_W-1:0] = cmp_q;
		if (hit_stat)
			rd_mux[4:0] = {seq_q, bus_released, monitor_sel, run_q};
		if (hit_istat)
			rd_mux[EV_W-1:0] = istat_q;
		if (hit_imask)
			rd_mux[EV_W-1:0] = imask_q;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else if (pclk_en && setup)
			prdata_q <= rd_mux;
	end
	assign prdata = prdata_q;
endmodule

//--- test/bbdc_props.sv
module bbdc_props
	import bbdc_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic              cpu_addr_valid,
	input wire logic              cpu_data_drive,
	input wire logic              cpu_instr_end,
	input wire logic              cpu_cc_mask,
	input wire logic              cpu_halted,
	input wire logic              irq_n,
	input wire logic              address_float_control,
	input wire logic              slow_memory_hold_n,
	input wire logic              cpu_irq_start,
	input wire logic              cpu_nmi_start,
	input wire logic              monitor_sel,
	input wire logic              phi2,
	input wire logic [ADDR_W-1:0] addr_oe_n,
	input wire logic              data_oe_n,
	input wire logic              valid_address_qualifier,
	input wire logic              bus_released,
	input wire logic              run_led,
	input wire logic              scope_trigger
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// A hold seen on two edges in a row with phase two up must freeze it.
	sequence s_held_high;
		!slow_memory_hold_n ##1 (!slow_memory_hold_n && phi2);
	endsequence

	AST_FLOAT_ADDR: assert property (address_float_control |-> &addr_oe_n)
		else $error("address lines driven while floated");
	AST_FLOAT_QUAL: assert property (address_float_control |->
		!valid_address_qualifier && !bus_released)
		else $error("qualifier or released flag high while floated");
	AST_DATA_KEEP: assert property (data_oe_n == !$past(cpu_data_drive))
		else $error("data enable does not follow the core");
	AST_VMA: assert property (!address_float_control |->
		valid_address_qualifier == $past(cpu_addr_valid))
		else $error("qualifier does not follow the core");
	AST_BUS_REL: assert property (cpu_halted ##1 !address_float_control
		|-> bus_released)
		else $error("released flag low while halted");
	AST_IRQ_GATE: assert property (cpu_irq_start |-> $past(cpu_instr_end)
		&& !$past(cpu_cc_mask) && !$past(irq_n))
		else $error("maskable sequence started out of turn");
	AST_NMI_BOUND: assert property (cpu_nmi_start |->
		$past(cpu_instr_end) && !cpu_irq_start)
		else $error("non-maskable sequence off a boundary");
	AST_PHI2_HOLD: assert property (s_held_high |=> phi2)
		else $error("phase two dropped during a memory hold");
	AST_PHI2_WIDTH: assert property ($rose(phi2) |=> phi2[*8])
		else $error("phase two pulse too short");
	AST_SCOPE: assert property (scope_trigger |-> $past(cpu_addr_valid))
		else $error("trigger without a valid address");
	AST_RUN: assert property (cpu_addr_valid |=>
		run_led == ($past(cpu_addr[15:12]) != MON_PAGE))
		else $error("run lamp wrong for last address");
	AST_MON_SEL: assert property (monitor_sel |->
		cpu_addr_valid && cpu_addr[15:12] == MON_PAGE)
		else $error("monitor select outside the top page");
endmodule

//--- test/bbdc_card_model.sv
module bbdc_card_model
#(
	parameter int HOLD = 150
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic phi2,
	input  wire logic cpu_irq_start,
	input  wire logic want_irq,
	input  wire logic want_slow,
	output logic      irq_n,
	output logic      slow_memory_hold_n
);
	logic irq_n_q;
	int   cnt_q;

	// The request stays low until the core answers, so a late boundary
	// cannot lose it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_n_q <= 1'b1;
		else if (cpu_irq_start)
			irq_n_q <= 1'b1;
		else if (want_irq)
			irq_n_q <= 1'b0;
	end

	// A slow access starts only with phase two up and lasts HOLD cycles.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= 0;
		else if (cnt_q != 0)
			cnt_q <= cnt_q - 1;
		else if (want_slow && phi2)
			cnt_q <= HOLD;
	end

	// Both lines are driven at all times.
	assign irq_n = irq_n_q;
	assign slow_memory_hold_n = (cnt_q == 0);
endmodule

//--- test/testbench.sv
module testbench;
	import bbdc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic               pclk, presetn, pclk_en, psel, penable, pwrite;
	logic [PADDR_W-1:0] paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic               pready, pslverr, perr, irq, cpu_addr_valid;
	logic [ADDR_W-1:0]  cpu_addr, addr_o, addr_oe_n;
	logic [DATA_W-1:0]  cpu_data, data_o;
	logic               cpu_data_drive, cpu_instr_end, cpu_cc_mask, cpu_halted;
	logic               cpu_waiting, cpu_init_done, cpu_reset, cpu_irq_start;
	logic               cpu_nmi_start, cpu_wake, monitor_go, monitor_sel;
	logic               irq_n, nmi_n, address_float_control, ext_clk, phi1;
	logic               slow_memory_hold_n, master_timing_clock, phi2;
	logic               data_oe_n, valid_address_qualifier, bus_released;
	logic               restart_n, abort_n, run_led, scope_trigger;
	logic               want_irq, want_slow;
	int                 fails, n_tests, k;

	bbdc_top i_dut (.*);
	bbdc_card_model i_card (.*);

	// Free-running bus clock, 10 ns period.
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// A hang is a mismatch and ends the run at once.
	task automatic stuck(input string nm);
		chk(nm, 1, 0);
		wrap_up();
	endtask

	task automatic wait_lv(ref logic s, input logic v, input string nm);
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (s !== v && k < 400);
		if (k == 400)
			stuck(nm);
	endtask

	// Setup, access until pready, then an idle edge so psel never
	// gets two assignments in one time step.
	task automatic apb(input logic wr, input logic [PADDR_W-1:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		wait_lv(pready, 1, "pready");
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic bus(input logic [15:0] a, input logic v);
		cpu_addr <= a;
		cpu_addr_valid <= v;
		repeat (2) @(posedge pclk);
	endtask

	task automatic boundary(input string nm, ref logic s, input logic v);
		@(posedge pclk);
		cpu_instr_end <= 1'b1;
		@(posedge pclk);
		cpu_instr_end <= 1'b0;
		@(posedge pclk);
		chk(nm, v, s);
	endtask

	task automatic boot();
		wait_lv(cpu_reset, 0, "reset end");
		cpu_init_done <= 1'b1;
		wait_lv(monitor_go, 1, "monitor entry");
		cpu_init_done <= 1'b0;
	endtask

	// Main sequence.
	initial
	begin
		{presetn, psel, penable, pwrite, cpu_addr_valid, cpu_halted} = '0;
		{cpu_data_drive, cpu_instr_end, cpu_cc_mask, cpu_waiting} = '0;
		{cpu_init_done, address_float_control, ext_clk, want_irq} = '0;
		{want_slow, paddr, pwdata, cpu_addr, cpu_data} = '0;
		{pclk_en, nmi_n, restart_n, abort_n} = '1;
		fails = 0;
		n_tests = 0;
		repeat (12) @(posedge pclk);
		chk("reset hold", 1, cpu_reset);
		presetn <= 1'b1;
		boot();
		apb(0, OFF_CTRL, 0);
		chk("ctrl reset", 32'h0000_0002, rd);
		apb(0, OFF_ISTAT, 0);
		chk("init event", 32'h0000_0008, rd);
		apb(0, 12'h020, 0);
		chk("unmapped data", 0, rd);
		chk("unmapped error", 1, perr);
		apb(1, OFF_ISTAT, 32'h0000_003F);
		apb(1, OFF_CMP, 32'h0000_1234);
		apb(1, OFF_CTRL, 32'h0000_0006);
		bus(16'h1234, 1);
		chk("scope trigger", 1, scope_trigger);
		apb(1, OFF_IMASK, 32'h0000_0001);
		chk("irq raised", 1, irq);
		apb(1, OFF_IMASK, 32'h0000_0000);
		chk("irq masked", 0, irq);
		// Park the core address first, or a live match sets the bit again.
		bus(16'h0000, 0);
		apb(1, OFF_ISTAT, 32'h0000_0001);
		apb(0, OFF_ISTAT, 0);
		chk("istat cleared", 0, rd);
		bus(16'hF000, 1);
		chk("run lamp top", 0, run_led);
		chk("monitor select", 1, monitor_sel);
		bus(16'h1000, 1);
		chk("run lamp user", 1, run_led);
		apb(1, OFF_CTRL, 32'h0000_0000);
		bus(16'hF000, 1);
		chk("monitor off", 0, monitor_sel);
		apb(1, OFF_CTRL, 32'h0000_0002);
		bus(16'h1234, 1);
		bus(16'h0000, 0);
		boundary("stop nmi", cpu_nmi_start, 1);
		abort_n <= 1'b0;
		@(posedge pclk);
		abort_n <= 1'b1;
		boundary("abort nmi", cpu_nmi_start, 1);
		cpu_cc_mask <= 1'b1;
		nmi_n <= 1'b0;
		@(posedge pclk);
		nmi_n <= 1'b1;
		boundary("pin nmi", cpu_nmi_start, 1);
		want_irq <= 1'b1;
		boundary("irq masked", cpu_irq_start, 0);
		cpu_cc_mask <= 1'b0;
		boundary("irq taken", cpu_irq_start, 1);
		want_irq <= 1'b0;
		apb(0, OFF_ISTAT, 0);
		chk("events", 32'h0000_0036, rd & 32'h0000_0036);
		cpu_halted <= 1'b1;
		cpu_data_drive <= 1'b1;
		bus(16'h1000, 1);
		chk("bus released", 1, bus_released);
		address_float_control <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("addr floated", 16'hFFFF, addr_oe_n);
		chk("qualifier low", 0, valid_address_qualifier);
		chk("released low", 0, bus_released);
		chk("data driven", 0, data_oe_n);
		{address_float_control, cpu_halted} <= 2'h0;
		bus(16'h1000, 1);
		chk("qualifier", 1, valid_address_qualifier);
		chk("address out", 32'h0000_1000, addr_o);
		// Switch sources while the master clock is low to avoid a runt.
		wait_lv(master_timing_clock, 0, "clock low");
		apb(1, OFF_CTRL, 32'h0000_0003);
		ext_clk <= 1'b1;
		repeat (10) @(posedge pclk);
		chk("ext clock high", 1, master_timing_clock);
		ext_clk <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("ext clock low", 0, master_timing_clock);
		chk("phase pair", !phi2, phi1);
		apb(1, OFF_CTRL, 32'h0000_0002);
		want_slow <= 1'b1;
		wait_lv(slow_memory_hold_n, 0, "slow hold");
		want_slow <= 1'b0;
		repeat (120) @(posedge pclk);
		chk("phase two held", 1, phi2);
		restart_n <= 1'b0;
		wait_lv(cpu_reset, 1, "restart");
		restart_n <= 1'b1;
		boot();
		wrap_up();
	end
endmodule

bind bbdc_top bbdc_props i_props (.*);
